// ===== src/message_ram_parity_guard.sv
// Parity generation, checking, error flags and data section layout for the message RAM
// Notes on behaviour
// [RULE_01] Data section holds zero to 254 bytes
// [RULE_02] RAM word is 32 data bits plus parity
// [RULE_03] Data partition follows last header word
// [RULE_04] Software keeps data pointers inside data partition
// [RULE_05] Section start from pointer, extent from length
// [RULE_06] Odd 16-bit count leaves upper half unused
// [RULE_07] Parity computed and stored on every write
// [RULE_08] Even parity over 32 data bits
// [RULE_09] Stored parity checked on every read
// [RULE_10] Error sets flag of affected RAM path
// [RULE_11] Error sets summary flag, interrupt if enabled
// [RULE_12] Full input transfer error: flag, indicators, no request
// [RULE_13] Data-only header error: indicators, no update, no request
// [RULE_14] Host input buffer read sets only its flag
// [RULE_15] Header scan error flags and skips buffer
// [RULE_16] RAM to transient error: no send, zero CRC
// [RULE_17] Transient to controller error: flag, zero CRC
// [RULE_18] Receive store errors flag and skip update
// [RULE_19] RAM to output buffer error sets indicators
// [RULE_20] Host output buffer read sets its flag
// [RULE_21] Preamble frame error keeps management vector unchanged
// [RULE_22] Bytes little-endian per word, parity bit 32
`timescale 1ns/1ns
module message_ram_parity_guard #(
  parameter int NUM_RAMS = parity_guard_pkg::NUM_RAMS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input parity_guard_pkg::ram_wr_t ram_wr [NUM_RAMS],
  output parity_guard_pkg::ram_rd_t ram_store [NUM_RAMS],
  input parity_guard_pkg::ram_rd_t ram_rd [NUM_RAMS],
  input parity_guard_pkg::xfer_ctx_t xfer_ctx,
  input parity_guard_pkg::section_cfg_t section_cfg,
  input wire logic byte_wr,
  input wire logic [7:0] byte_index,
  input wire logic [7:0] byte_value,
  output logic [parity_guard_pkg::ADDR_W-1:0] byte_word_addr,
  output logic [3:0] byte_lane_en,
  output logic [31:0] byte_lane_data,
  output parity_guard_pkg::section_span_t section_span,
  output logic suppress_tx_request,
  output logic skip_buffer,
  output logic hold_data_section,
  output logic [1:0] zero_frame_crc,
  output logic hold_net_mgmt_vector,
  output logic error_irq
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_sync1_ff;
  logic rst_n_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_n_ff <= rst_sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Parity generation and check
  // ----------------------------------------------------------------
  logic [NUM_RAMS-1:0] par_err;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RAMS; gi++) begin : g_ram
      always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          ram_store[gi] <= '0;
        end else begin
          ram_store[gi].en <= ram_wr[gi].en;
          if (ram_wr[gi].en) begin
            ram_store[gi].word <= {^ram_wr[gi].data, ram_wr[gi].data}; // RULE_07 RULE_08 RULE_02
          end
        end
      end
      // A mismatch between data ones and stored bit flags the word
      assign par_err[gi] = ram_rd[gi].en &&
        ((^ram_rd[gi].word[parity_guard_pkg::DATA_W-1:0]) !=
         ram_rd[gi].word[parity_guard_pkg::PAR_BIT]); // RULE_09
    end
  endgenerate

  // ----------------------------------------------------------------
  // Error classification by path and transfer
  // ----------------------------------------------------------------
  logic err_ibf;
  logic err_obf;
  logic err_msg;
  logic err_tbf1;
  logic err_tbf2;
  logic err_tbf;
  logic err_any;
  logic mark_faulty;
  logic nxt_suppress;
  logic nxt_skip;
  logic nxt_hold;
  logic [1:0] nxt_zero_crc;
  logic nxt_nmv_hold;
  parity_guard_pkg::xfer_kind_t kind;
  assign kind = xfer_ctx.kind;
  assign err_ibf = par_err[parity_guard_pkg::RAM_IBF1] | par_err[parity_guard_pkg::RAM_IBF2];
  assign err_obf = par_err[parity_guard_pkg::RAM_OBF1] | par_err[parity_guard_pkg::RAM_OBF2];
  assign err_msg = par_err[parity_guard_pkg::RAM_MSG];
  assign err_tbf1 = par_err[parity_guard_pkg::RAM_TBF1];
  assign err_tbf2 = par_err[parity_guard_pkg::RAM_TBF2];
  assign err_tbf = err_tbf1 | err_tbf2;
  assign err_any = |par_err;

  always_comb begin
    mark_faulty = 1'b0;
    nxt_suppress = 1'b0;
    nxt_skip = 1'b0;
    nxt_hold = 1'b0;
    nxt_zero_crc = 2'h0;
    nxt_nmv_hold = 1'b0;
    unique case (kind)
      parity_guard_pkg::XF_IBF_FULL: begin
        if (err_ibf || err_msg) begin
          mark_faulty = 1'b1; // RULE_12
          nxt_suppress = 1'b1; // RULE_12
        end
      end
      parity_guard_pkg::XF_IBF_DATA: begin
        if (err_msg) begin
          mark_faulty = 1'b1; // RULE_13
          nxt_hold = 1'b1; // RULE_13
          nxt_suppress = 1'b1; // RULE_13
        end
      end
      parity_guard_pkg::XF_HDR_SCAN: begin
        if (err_msg) begin
          mark_faulty = 1'b1; // RULE_15
          nxt_skip = 1'b1; // RULE_15
        end
      end
      parity_guard_pkg::XF_MR_TO_TBF: begin
        if (err_msg) begin
          mark_faulty = 1'b1; // RULE_16
          nxt_suppress = 1'b1; // RULE_16
          nxt_zero_crc[xfer_ctx.channel] = 1'b1; // RULE_16
        end
      end
      parity_guard_pkg::XF_TBF_TO_PC: begin
        if (err_tbf) begin
          nxt_zero_crc = {err_tbf2, err_tbf1}; // RULE_17
        end
      end
      parity_guard_pkg::XF_TBF_TO_MR: begin
        if (err_msg || err_tbf) begin
          mark_faulty = 1'b1; // RULE_18
        end
        if (err_msg) begin
          nxt_hold = 1'b1; // RULE_18
        end
        if (err_tbf && xfer_ctx.preamble_indicator) begin
          nxt_nmv_hold = 1'b1; // RULE_21
        end
      end
      parity_guard_pkg::XF_MR_TO_OBF: begin
        if (err_msg) begin
          mark_faulty = 1'b1; // RULE_19
        end
      end
      parity_guard_pkg::XF_IDLE,
      parity_guard_pkg::XF_HOST_IBF,
      parity_guard_pkg::XF_HOST_OBF: begin
        // Host reads touch only the path flag, no indicators
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      suppress_tx_request <= 1'b0;
      skip_buffer <= 1'b0;
      hold_data_section <= 1'b0;
      zero_frame_crc <= 2'h0;
      hold_net_mgmt_vector <= 1'b0;
    end else begin
      suppress_tx_request <= nxt_suppress;
      skip_buffer <= nxt_skip;
      hold_data_section <= nxt_hold;
      zero_frame_crc <= nxt_zero_crc;
      hold_net_mgmt_vector <= nxt_nmv_hold;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave with one wait state
  // ----------------------------------------------------------------
  logic ack_ff;
  logic bus_req;
  logic wr_take;
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign wr_take = avs_write & ack_ff;

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic status, summary flag and enable
  // ----------------------------------------------------------------
  logic [31:0] diag_ff;
  logic [31:0] diag_clr;
  logic [31:0] diag_set;
  logic parity_error_summary_ff;
  logic parity_error_summary_en_ff;
  logic fbv_now;
  assign diag_clr = (wr_take && avs_address == parity_guard_pkg::REG_DIAG) ?
                    avs_writedata : 32'h0000_0000;
  assign fbv_now = diag_ff[parity_guard_pkg::DS_FBV] & ~diag_clr[parity_guard_pkg::DS_FBV];

  always_comb begin
    diag_set = 32'h0000_0000;
    diag_set[parity_guard_pkg::DS_IBF] = err_ibf; // RULE_10 RULE_14
    diag_set[parity_guard_pkg::DS_OBF] = err_obf; // RULE_10 RULE_20
    diag_set[parity_guard_pkg::DS_MSG] = err_msg; // RULE_10
    diag_set[parity_guard_pkg::DS_TBF1] = err_tbf1; // RULE_10
    diag_set[parity_guard_pkg::DS_TBF2] = err_tbf2; // RULE_10
    diag_set[parity_guard_pkg::DS_FBV] = mark_faulty;
    diag_set[parity_guard_pkg::DS_MULTI] = mark_faulty & fbv_now;
  end

  // Set beats clear so an error in the clearing cycle is kept
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      diag_ff <= parity_guard_pkg::DIAG_RESET;
    end else begin
      diag_ff[parity_guard_pkg::DS_MULTI:0] <=
        (diag_ff[parity_guard_pkg::DS_MULTI:0] & ~diag_clr[parity_guard_pkg::DS_MULTI:0]) |
        diag_set[parity_guard_pkg::DS_MULTI:0];
      // The first faulty number is kept until software clears the valid bit
      if (mark_faulty && !fbv_now) begin
        diag_ff[parity_guard_pkg::DS_FBN_HI:parity_guard_pkg::DS_FBN_LO] <=
          xfer_ctx.buf_num; // RULE_12 RULE_13 RULE_15 RULE_16 RULE_18 RULE_19
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      parity_error_summary_ff <= 1'b0;
      parity_error_summary_en_ff <= 1'b0;
    end else begin
      if (err_any) begin
        parity_error_summary_ff <= 1'b1; // RULE_11
      end else if (wr_take && avs_address == parity_guard_pkg::REG_ERR_FLAGS &&
                   avs_writedata[parity_guard_pkg::EF_PARITY_ERROR_SUMMARY]) begin
        parity_error_summary_ff <= 1'b0;
      end
      if (wr_take && avs_address == parity_guard_pkg::REG_ERR_ENABLE) begin
        parity_error_summary_en_ff <= avs_writedata[parity_guard_pkg::EF_PARITY_ERROR_SUMMARY];
      end
    end
  end
  assign error_irq = parity_error_summary_ff & parity_error_summary_en_ff; // RULE_11

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      unique case (avs_address)
        parity_guard_pkg::REG_DIAG: avs_readdata <= diag_ff;
        parity_guard_pkg::REG_ERR_FLAGS: avs_readdata <= 32'(parity_error_summary_ff) << parity_guard_pkg::EF_PARITY_ERROR_SUMMARY;
        parity_guard_pkg::REG_ERR_ENABLE: avs_readdata <= 32'(parity_error_summary_en_ff) << parity_guard_pkg::EF_PARITY_ERROR_SUMMARY;
        default: avs_readdata <= parity_guard_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data section layout
  // ----------------------------------------------------------------
  logic [parity_guard_pkg::ADDR_W-1:0] words_needed;
  logic [parity_guard_pkg::ADDR_W-1:0] hdr_end;
  logic [parity_guard_pkg::ADDR_W-1:0] last_calc;
  assign words_needed = parity_guard_pkg::ADDR_W'((section_cfg.payload_len + 8'h01) >> 1); // RULE_05
  assign hdr_end = parity_guard_pkg::ADDR_W'(section_cfg.hdr_buffers *
                   parity_guard_pkg::HDR_WORDS_PER_BUF); // RULE_03
  assign last_calc = (words_needed == '0) ? section_cfg.data_ptr :
                     parity_guard_pkg::ADDR_W'(section_cfg.data_ptr + words_needed - 1'b1);

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      section_span <= '0;
    end else begin
      section_span.first_word <= section_cfg.data_ptr; // RULE_05
      section_span.last_word <= last_calc; // RULE_05
      section_span.word_count <= words_needed;
      section_span.upper_half_unused <= section_cfg.payload_len[0]; // RULE_06
      // Software must keep pointers above the header partition; this only reports it
      section_span.ptr_in_partition <= section_cfg.data_ptr >= hdr_end; // RULE_04 RULE_03
      section_span.length_ok <= ({section_cfg.payload_len, 1'b0} <=
                                 8'(parity_guard_pkg::MAX_PAYLOAD_BYTES)); // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // Payload byte placement
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      byte_word_addr <= '0;
      byte_lane_en <= 4'h0;
      byte_lane_data <= 32'h0000_0000;
    end else begin
      byte_lane_en <= 4'h0;
      if (byte_wr) begin
        byte_word_addr <= parity_guard_pkg::ADDR_W'(section_cfg.data_ptr + (byte_index >> 2));
        byte_lane_en <= 4'h1 << byte_index[1:0]; // RULE_22
        byte_lane_data <= {4{byte_value}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_scan_err;
    err_msg && kind == parity_guard_pkg::XF_HDR_SCAN;
  endsequence
  sequence s_skip_out;
    skip_buffer && diag_ff[parity_guard_pkg::DS_MSG] && diag_ff[parity_guard_pkg::DS_FBV];
  endsequence

  chk_store_parity: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    ram_wr[parity_guard_pkg::RAM_MSG].en |=> // RULE_07
    ^ram_store[parity_guard_pkg::RAM_MSG].word == 1'b0)
    else $error("stored word has odd parity");
  chk_summary_set: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    err_any |=> parity_error_summary_ff) // RULE_11
    else $error("summary flag not set after parity error");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    err_any && parity_error_summary_en_ff && !wr_take |=> error_irq) // RULE_11
    else $error("enabled parity error raised no interrupt");
  chk_scan_skip: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    s_scan_err |=> s_skip_out) // RULE_15
    else $error("scan error did not skip buffer");
  chk_host_ibf_only: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    kind == parity_guard_pkg::XF_HOST_IBF && err_ibf && !err_msg && !err_tbf && !err_obf
    |=> diag_ff[parity_guard_pkg::DS_IBF] && !suppress_tx_request && !skip_buffer) // RULE_14
    else $error("host input read error had side effects");
  chk_full_xfer: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    kind == parity_guard_pkg::XF_IBF_FULL && err_ibf |=>
    suppress_tx_request && diag_ff[parity_guard_pkg::DS_IBF] &&
    diag_ff[parity_guard_pkg::DS_FBV]) // RULE_12
    else $error("input transfer error not handled");
  chk_crc_zero: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    kind == parity_guard_pkg::XF_TBF_TO_PC && err_tbf1 |=>
    zero_frame_crc[0] && diag_ff[parity_guard_pkg::DS_TBF1]) // RULE_17
    else $error("frame CRC not zeroed on transient error");
  chk_obf_flag: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    err_obf |=> diag_ff[parity_guard_pkg::DS_OBF]) // RULE_20
    else $error("output buffer flag not set");
  chk_nmv_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    kind == parity_guard_pkg::XF_TBF_TO_MR && err_tbf && xfer_ctx.preamble_indicator
    |=> hold_net_mgmt_vector) // RULE_21
    else $error("management vector not held");
  chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n_ff)
    $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
endmodule : message_ram_parity_guard

// ===== src/parity_guard_pkg.sv
// Package: constants and carriers for the message RAM parity guard
package parity_guard_pkg;
  // ----------------------------------------------------------------
  // RAM geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int WORD_W = 33;
  localparam int PAR_BIT = 32;
  localparam int ADDR_W = 11;
  localparam int NUM_RAMS = 7;
  localparam int PLEN_W = 7;
  localparam int MAX_PAYLOAD_BYTES = 254;
  localparam int HDR_WORDS_PER_BUF = 4;
  localparam int BUFNUM_W = 7;
  // ----------------------------------------------------------------
  // RAM block indices
  // ----------------------------------------------------------------
  localparam int RAM_IBF1 = 0;
  localparam int RAM_IBF2 = 1;
  localparam int RAM_OBF1 = 2;
  localparam int RAM_OBF2 = 3;
  localparam int RAM_MSG = 4;
  localparam int RAM_TBF1 = 5;
  localparam int RAM_TBF2 = 6;
  // ----------------------------------------------------------------
  // Register map (word index on the bus)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_DIAG = 2'h0;
  localparam logic [1:0] REG_ERR_FLAGS = 2'h1;
  localparam logic [1:0] REG_ERR_ENABLE = 2'h2;
  // handler_diag_status fields
  localparam int DS_IBF = 0;
  localparam int DS_OBF = 1;
  localparam int DS_MSG = 2;
  localparam int DS_TBF1 = 3;
  localparam int DS_TBF2 = 4;
  localparam int DS_FBV = 5;
  localparam int DS_MULTI = 6;
  localparam int DS_FBN_LO = 8;
  localparam int DS_FBN_HI = 14;
  // error_irq_flags / enable field
  localparam int EF_PARITY_ERROR_SUMMARY = 6;
  localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Transfer under way when a word is read
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    XF_IDLE       = 10'h001,
    XF_IBF_FULL   = 10'h002,
    XF_IBF_DATA   = 10'h004,
    XF_HOST_IBF   = 10'h008,
    XF_HDR_SCAN   = 10'h010,
    XF_MR_TO_TBF  = 10'h020,
    XF_TBF_TO_PC  = 10'h040,
    XF_TBF_TO_MR  = 10'h080,
    XF_MR_TO_OBF  = 10'h100,
    XF_HOST_OBF   = 10'h200
  } xfer_kind_t;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [DATA_W-1:0] data;
  } ram_wr_t;
  typedef struct packed {
    logic en;
    logic [WORD_W-1:0] word;
  } ram_rd_t;
  typedef struct packed {
    xfer_kind_t kind;
    logic [BUFNUM_W-1:0] buf_num;
    logic channel;
    logic preamble_indicator;
  } xfer_ctx_t;
  typedef struct packed {
    logic [ADDR_W-1:0] data_ptr;
    logic [PLEN_W-1:0] payload_len;
    logic [BUFNUM_W:0] hdr_buffers;
  } section_cfg_t;
  typedef struct packed {
    logic [ADDR_W-1:0] first_word;
    logic [ADDR_W-1:0] last_word;
    logic [ADDR_W-1:0] word_count;
    logic upper_half_unused;
    logic ptr_in_partition;
    logic length_ok;
  } section_span_t;
endpackage : parity_guard_pkg

// ===== testbench/ram_blocks_model.sv
// Model of the seven RAM blocks behind the parity guard
`timescale 1ns/1ns
module ram_blocks_model (
  input wire logic sys_clk,
  input parity_guard_pkg::ram_rd_t ram_store [parity_guard_pkg::NUM_RAMS],
  input wire logic [6:0] rd_req,
  input wire logic flip,
  output parity_guard_pkg::ram_rd_t ram_rd [parity_guard_pkg::NUM_RAMS]
);
  // ----------------------------------------------------------------
  // Storage and read port
  // ----------------------------------------------------------------
  logic [32:0] mem_ff [7];
  initial for (int i = 0; i < 7; i++) mem_ff[i] = 33'h0;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 7; i++) if (ram_store[i].en) mem_ff[i] <= ram_store[i].word;
  end
  // Idle port shows the inverse so a stale word never passes for a fresh one
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      ram_rd[i].en = rd_req[i];
      ram_rd[i].word = rd_req[i] ? mem_ff[i] ^ {flip, 32'h0} : ~mem_ff[i];
    end
  end
endmodule : ram_blocks_model

// ===== testbench/tb_top.sv
// Self-checking testbench for the message RAM parity guard
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Signals, design and partner
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  parity_guard_pkg::ram_wr_t ram_wr [parity_guard_pkg::NUM_RAMS];
  parity_guard_pkg::ram_rd_t ram_store [parity_guard_pkg::NUM_RAMS];
  parity_guard_pkg::ram_rd_t ram_rd [parity_guard_pkg::NUM_RAMS];
  parity_guard_pkg::xfer_ctx_t xfer_ctx = '{parity_guard_pkg::XF_IDLE, 7'h0, 1'b0, 1'b0};
  parity_guard_pkg::section_cfg_t section_cfg = '0;
  parity_guard_pkg::section_span_t section_span;
  logic byte_wr = 1'b0;
  logic [7:0] byte_index = 8'h0, byte_value = 8'h0;
  logic [10:0] byte_word_addr;
  logic [3:0] byte_lane_en;
  logic [31:0] byte_lane_data;
  logic suppress_tx_request, skip_buffer, hold_data_section, hold_net_mgmt_vector, error_irq;
  logic [1:0] zero_frame_crc;
  logic [6:0] rd_req = 7'h0;
  logic flip = 1'b0;
  int errors = 0;
  int checks = 0;
  integer seed = 32'h5D8F;
  initial for (int i = 0; i < 7; i++) ram_wr[i] = '0;
  always #25 sys_clk = ~sys_clk;
  message_ram_parity_guard u_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ram_wr(ram_wr),
    .ram_store(ram_store), .ram_rd(ram_rd), .xfer_ctx(xfer_ctx), .section_cfg(section_cfg),
    .byte_wr(byte_wr), .byte_index(byte_index), .byte_value(byte_value),
    .byte_word_addr(byte_word_addr), .byte_lane_en(byte_lane_en),
    .byte_lane_data(byte_lane_data), .section_span(section_span),
    .suppress_tx_request(suppress_tx_request), .skip_buffer(skip_buffer),
    .hold_data_section(hold_data_section), .zero_frame_crc(zero_frame_crc),
    .hold_net_mgmt_vector(hold_net_mgmt_vector), .error_irq(error_irq));
  ram_blocks_model u_ram (.sys_clk(sys_clk), .ram_store(ram_store), .rd_req(rd_req),
    .flip(flip), .ram_rd(ram_rd));
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // Waitrequest is looked at settled, before the edge that ends each cycle
  task bus_rd(input logic [1:0] a, output logic [31:0] d);
    logic done;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(negedge sys_clk);
      done = (avs_waitrequest === 1'b0);
      d = avs_readdata;
      @(posedge sys_clk);
    end while (!done);
    avs_read <= 1'b0;
  endtask : bus_rd
  task bus_wr(input logic [1:0] a, input logic [31:0] d);
    logic done;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(negedge sys_clk);
      done = (avs_waitrequest === 1'b0);
      @(posedge sys_clk);
    end while (!done);
    avs_write <= 1'b0;
  endtask : bus_wr
  task ram_write(input int r, input logic [31:0] d);
    @(posedge sys_clk);
    ram_wr[r] <= '{1'b1, d};
    @(posedge sys_clk);
    ram_wr[r] <= '{1'b0, ~d};
    @(negedge sys_clk);
    chk(ram_store[r].en, 1, "store enable");
    chk(ram_store[r].word[31:0], d, "store data");
    chk(ram_store[r].word[32], ^d, "store parity");
  endtask : ram_write
  task ram_read(input int k, input int r, input logic [6:0] b, input logic c, input logic p,
      input logic bad);
    @(posedge sys_clk);
    xfer_ctx <= '{parity_guard_pkg::xfer_kind_t'(10'h1 << k), b, c, p};
    rd_req <= 7'h1 << r;
    flip <= bad;
    @(posedge sys_clk);
    rd_req <= 7'h0;
    flip <= 1'b0;
    @(negedge sys_clk);
  endtask : ram_read
  // Result bits: faulty, suppress, skip, hold data, crc1, crc0, hold vector
  function automatic logic [6:0] exp_act(input int k, input int r, input logic c, input logic p);
    logic m;
    logic t;
    m = (r == parity_guard_pkg::RAM_MSG);
    t = (r > parity_guard_pkg::RAM_MSG);
    case (k)
      1: return (m || r < 2) ? 7'h60 : 7'h0;
      2: return m ? 7'h68 : 7'h0;
      4: return m ? 7'h50 : 7'h0;
      5: return m ? (c ? 7'h64 : 7'h62) : 7'h0;
      6: return t ? ((r == parity_guard_pkg::RAM_TBF1) ? 7'h02 : 7'h04) : 7'h0;
      7: return m ? 7'h48 : (t ? {6'h20, p} : 7'h0);
      8: return m ? 7'h40 : 7'h0;
      default: return 7'h0;
    endcase
  endfunction : exp_act
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    static int kk[13] = '{1, 1, 2, 3, 4, 5, 6, 6, 7, 7, 8, 9, 0};
    static int rr[13] = '{0, 4, 4, 1, 4, 4, 6, 5, 4, 5, 4, 3, 2};
    static int pb[7] = '{0, 0, 1, 1, 2, 3, 4};
    logic [31:0] q;
    logic [6:0] e;
    logic c, p, en;
    logic [7:0] bi, bv;
    logic [10:0] wc;
    parity_guard_pkg::section_cfg_t cfg;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus_rd(parity_guard_pkg::REG_DIAG, q);
    chk(q, parity_guard_pkg::DIAG_RESET, "diag reset");
    bus_wr(2'h3, 32'hFFFF_FFFF);
    bus_rd(2'h3, q);
    chk(q, parity_guard_pkg::UNMAPPED_READ, "unmapped read");
    for (int i = 0; i < 13; i++) begin
      c = 1'($random(seed));
      p = (i == 9) ? 1'b1 : 1'($random(seed));
      en = 1'($random(seed));
      bus_wr(parity_guard_pkg::REG_DIAG, 32'h7F);
      bus_wr(parity_guard_pkg::REG_ERR_FLAGS, 32'h40);
      bus_wr(parity_guard_pkg::REG_ERR_ENABLE, {25'h0, en, 6'h0});
      ram_write(rr[i], (i < 2) ? 32'h3 << i : $random(seed));
      ram_read(kk[i], rr[i], 7'(i + 3), c, p, 1'b0);
      chk({suppress_tx_request, skip_buffer, hold_data_section, zero_frame_crc,
        hold_net_mgmt_vector}, 0, "clean read action");
      ram_read(kk[i], rr[i], 7'(i + 3), c, p, 1'b1);
      e = exp_act(kk[i], rr[i], c, p);
      chk({suppress_tx_request, skip_buffer, hold_data_section, zero_frame_crc,
        hold_net_mgmt_vector}, e[5:0], "error action");
      bus_rd(parity_guard_pkg::REG_DIAG, q);
      chk(q[4:0], 5'h1 << pb[rr[i]], "path flag");
      chk(q[5], e[6], "faulty valid");
      if (e[6]) chk(q[14:8], i + 3, "faulty number");
      bus_rd(parity_guard_pkg::REG_ERR_FLAGS, q);
      chk(q[6], 1, "summary flag");
      chk(error_irq, en, "irq level");
    end
    bus_wr(parity_guard_pkg::REG_DIAG, 32'h7F);
    bus_wr(parity_guard_pkg::REG_ERR_ENABLE, 32'h40);
    bus_wr(parity_guard_pkg::REG_ERR_FLAGS, 32'h40);
    @(negedge sys_clk);
    chk(error_irq, 0, "irq cleared");
    ram_read(4, 4, 7'h11, 1'b0, 1'b0, 1'b1);
    ram_read(4, 4, 7'h22, 1'b0, 1'b0, 1'b1);
    bus_rd(parity_guard_pkg::REG_DIAG, q);
    chk({q[14:8], q[6:5]}, {7'h11, 2'h3}, "second fault");
    for (int i = 0; i < 20; i++) begin
      // Pointer may land below the partition to exercise its range check
      cfg = '{11'($random(seed)), 7'($random(seed)), 8'({$random(seed)} % 129)};
      if (i == 0) cfg.payload_len = 7'h0;
      if (i == 1) cfg.payload_len = 7'h7F;
      @(posedge sys_clk);
      section_cfg <= cfg;
      @(posedge sys_clk);
      @(negedge sys_clk);
      wc = 11'((cfg.payload_len + 1) / 2);
      chk(section_span.first_word, cfg.data_ptr, "first word");
      chk(section_span.word_count, wc, "word count");
      if (wc != 0) chk(section_span.last_word, 11'(cfg.data_ptr + wc - 1), "last");
      chk(section_span.upper_half_unused, cfg.payload_len[0], "upper half");
      chk(section_span.ptr_in_partition, cfg.data_ptr >= 4 * cfg.hdr_buffers, "ptr");
      chk(section_span.length_ok, 1, "length");
      bi = (i == 1) ? 8'hFD : 8'({$random(seed)} % 254);
      bv = 8'($random(seed));
      @(posedge sys_clk);
      byte_wr <= 1'b1;
      byte_index <= bi;
      byte_value <= bv;
      @(posedge sys_clk);
      byte_wr <= 1'b0;
      @(negedge sys_clk);
      chk(byte_word_addr, 11'(cfg.data_ptr + bi / 4), "byte word");
      chk(byte_lane_en, 4'h1 << bi[1:0], "byte lane");
      chk(byte_lane_data, {4{bv}}, "byte data");
    end
    summarize();
  end
  initial begin
    #2000000;
    errors++;
    summarize();
  end
endmodule : tb_top
